// ==== verilog/vdcc_regs.sv ====
// Contract
// - manual bit forces coded standard, else autodetect
// - standard codes zero to six, PAL-B/D default
// - autodetect without video free-runs coded standard
// - AGC enable bit, off by default
// - setup bit chooses 7.5 or 0 IRE black
// - nonstandard flag reads source nonstandard state
// - field rate flag: one sixty, zero fifty
// - status bits report colour and loop locks
// - ten-bit horizontal start, default 32
// - ten-bit horizontal count, default 720
// - nine-bit vertical start, default 6
// - nine-bit vertical count, default 240
// - hue linear, 128 means no shift
// - saturation 0.8 percent steps, default 128
// - contrast scales luma, default 128
// - brightness 0.2 IRE steps, default 128
// - comb adaptive for 0,1; trap for 2
// - peaking band bit and 12.5 percent gain
// - colour killer auto, always on, always killed
// - transient gain 12.5 percent steps, default 6
// - backdrop enable, colour only while enabled
// - soft reset self-clears, keeps control registers
// - dual-stream bit selects multiplexed output
// - partner select picks channel to multiplex
`default_nettype none
module vdcc_regs
  import vdcc_pkg::*;
#(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // two-wire host pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [1:0] sadd_i,
  // per-channel status from decoder core
  input wire logic [NCH*3-1:0] det_standard,
  input wire logic [NCH-1:0] video_present,
  input wire logic [NCH-1:0] color_detected,
  input wire logic [NCH-1:0] color_locked,
  input wire logic [NCH-1:0] agc_locked,
  input wire logic [NCH-1:0] clamp_loop_locked,
  input wire logic [NCH-1:0] line_pll_locked,
  input wire logic [NCH-1:0] nonstandard_flag,
  input wire logic [NCH-1:0] field_rate_flag,
  // standard and gain controls
  output logic [NCH*3-1:0] std_active,
  output logic [NCH-1:0] agc_enable,
  output logic [NCH-1:0] setup_level_enable,
  // active window
  output logic [NCH*10-1:0] h_active_start,
  output logic [NCH*10-1:0] h_active_count,
  output logic [NCH*9-1:0] v_active_start,
  output logic [NCH*9-1:0] v_active_count,
  // picture adjustment
  output logic [NCH*8-1:0] hue_shift,
  output logic [NCH*8-1:0] saturation_gain,
  output logic [NCH*8-1:0] contrast_gain,
  output logic [NCH*8-1:0] brightness_offset,
  // luma and chroma processing
  output logic [NCH-1:0] luma_bandwidth_select,
  output logic [NCH-1:0] comb_force_trap,
  output logic [NCH-1:0] peaking_band_select,
  output logic [NCH*4-1:0] peaking_gain,
  output logic [NCH-1:0] chroma_force_on,
  output logic [NCH-1:0] chroma_force_kill,
  output logic [NCH*4-1:0] transient_boost_gain,
  // channel control
  output logic [NCH-1:0] backdrop_enable,
  output logic [NCH-1:0] backdrop_black,
  output logic [NCH-1:0] soft_reset,
  output logic [NCH-1:0] dual_stream_enable,
  output logic [NCH*2-1:0] partner_channel_select
);
  logic [7:0] reg_idx;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] ch_rd [NCH];

  // true when the index falls in this channel's block
  function automatic logic ch_hit(input logic [7:0] idx, input int ch);
    ch_hit = (idx[7:CH_LSB+CH_W] == IDX_TOP_ZERO) &&
      (int'(idx[CH_LSB+CH_W-1:CH_LSB]) == ch);
  endfunction

  // masked byte update: only writable bits take new data
  function automatic logic [7:0] wmask(input logic [7:0] old,
      input logic [7:0] nw, input logic [7:0] msk);
    wmask = (old & ~msk) | (nw & msk);
  endfunction

  vdcc_serial_slave u_slave (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n(sda_oe_n),
    .sadd_i(sadd_i),
    .reg_idx(reg_idx),
    .wr_stb(wr_stb),
    .wr_data(wr_data),
    .rd_data(rd_data)
  );

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [7:0] fmt_q, hs_lo_q, hc_lo_q, vs_lo_q, vc_lo_q, winhi_q;
      logic [7:0] hue_q, sat_q, cont_q, brt_q, luma_q, chroma_q, chan_q;
      logic [2:0] srst_cnt_q;
      logic [2:0] std_q;
      logic trap_q, alive_q, kill_q, black_q;
      logic wr_here;
      logic [3:0] rsel;
      logic [7:0] status;
      logic [7:0] fmt_rd;

      assign wr_here = wr_stb && ch_hit(reg_idx, g);
      assign rsel = reg_idx[REG_W-1:0];

      // control registers; soft reset never touches these
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          fmt_q <= RST_FORMAT;
          hs_lo_q <= RST_HSTART;
          hc_lo_q <= RST_HCOUNT;
          vs_lo_q <= RST_VSTART;
          vc_lo_q <= RST_VCOUNT;
          winhi_q <= RST_WINHI;
          hue_q <= RST_MID;
          sat_q <= RST_MID;
          cont_q <= RST_MID;
          brt_q <= RST_MID;
          luma_q <= RST_LUMA;
          chroma_q <= RST_CHROMA;
          chan_q <= RST_CHAN;
        end else if (wr_here) begin
          case (rsel)
            OFS_FORMAT: fmt_q <= wmask(fmt_q, wr_data, FMT_WMASK);
            OFS_HSTART: hs_lo_q <= wr_data;
            OFS_HCOUNT: hc_lo_q <= wr_data;
            OFS_VSTART: vs_lo_q <= wr_data;
            OFS_VCOUNT: vc_lo_q <= wr_data;
            OFS_WINHI: winhi_q <= wmask(winhi_q, wr_data, WIN_WMASK);
            OFS_HUE: hue_q <= wr_data;
            OFS_SAT: sat_q <= wr_data;
            OFS_CONT: cont_q <= wr_data;
            OFS_BRT: brt_q <= wr_data;
            OFS_LUMA: luma_q <= wr_data;
            OFS_CHROMA: chroma_q <= wmask(chroma_q, wr_data, CHR_WMASK);
            OFS_CHAN: chan_q <= wmask(chan_q, wr_data, CHAN_WMASK);
            default: chan_q <= chan_q;
          endcase
        end else if (srst_cnt_q == 3'h1) begin
          // self-clearing: drop the bit as the pulse ends
          chan_q[CHAN_SRST_BIT] <= 1'b0;
        end
      end

      // soft reset pulse; a fresh write of 1 restarts the count
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          srst_cnt_q <= 3'h0;
        end else if (wr_here && rsel == OFS_CHAN &&
            wr_data[CHAN_SRST_BIT]) begin
          srst_cnt_q <= SRST_CYCLES;
        end else if (srst_cnt_q != 3'h0) begin
          srst_cnt_q <= srst_cnt_q - 3'h1;
        end
      end

      // decoded modes registered so outputs come from flops
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          std_q <= STD_PAL_BD;
          trap_q <= 1'b0;
          alive_q <= 1'b0;
          kill_q <= 1'b0;
          black_q <= 1'b0;
        end else begin
          // manual wins; auto without video free-runs the code
          if (fmt_q[FMT_MAN_BIT] || !video_present[g])
            std_q <= fmt_q[FMT_STD_LSB +: 3];
          else
            std_q <= det_standard[g*3 +: 3];
          // code 3 is unsupported; it stays adaptive
          trap_q <= luma_q[LUMA_COMB_LSB +: 2] == COMB_TRAP;
          alive_q <= chroma_q[CHR_KILL_LSB +: 2] == KILL_ALIVE;
          kill_q <= chroma_q[CHR_KILL_LSB +: 2] == KILL_ALWAYS;
          // colour means nothing while the backdrop is off
          black_q <= chan_q[CHAN_BGEN_BIT] & chan_q[CHAN_BGCLR_BIT];
        end
      end

      // status word; detected standard above the lock bits
      assign status = {det_standard[g*3 +: 3], color_detected[g],
        color_locked[g], agc_locked[g], clamp_loop_locked[g],
        line_pll_locked[g]};
      assign fmt_rd = {fmt_q[7:2], nonstandard_flag[g],
        field_rate_flag[g]};

      // per-channel read mux; unmapped offsets read zero
      always_comb begin
        case (rsel)
          OFS_STATUS: ch_rd[g] = status;
          OFS_FORMAT: ch_rd[g] = fmt_rd;
          OFS_HSTART: ch_rd[g] = hs_lo_q;
          OFS_HCOUNT: ch_rd[g] = hc_lo_q;
          OFS_VSTART: ch_rd[g] = vs_lo_q;
          OFS_VCOUNT: ch_rd[g] = vc_lo_q;
          OFS_WINHI: ch_rd[g] = winhi_q;
          OFS_HUE: ch_rd[g] = hue_q;
          OFS_SAT: ch_rd[g] = sat_q;
          OFS_CONT: ch_rd[g] = cont_q;
          OFS_BRT: ch_rd[g] = brt_q;
          OFS_LUMA: ch_rd[g] = luma_q;
          OFS_CHROMA: ch_rd[g] = chroma_q;
          OFS_CHAN: ch_rd[g] = chan_q;
          default: ch_rd[g] = 8'h00;
        endcase
      end

      // standard and gain controls
      assign std_active[g*3 +: 3] = std_q;
      assign agc_enable[g] = fmt_q[FMT_AGC_BIT];
      assign setup_level_enable[g] = fmt_q[FMT_SETUP_BIT];

      // window fields joined from shared high bits and low bytes
      assign h_active_start[g*10 +: 10] =
        {winhi_q[WIN_HS_LSB +: 2], hs_lo_q};
      assign h_active_count[g*10 +: 10] =
        {winhi_q[WIN_HC_LSB +: 2], hc_lo_q};
      assign v_active_start[g*9 +: 9] =
        {winhi_q[WIN_VS_BIT], vs_lo_q};
      assign v_active_count[g*9 +: 9] =
        {winhi_q[WIN_VC_BIT], vc_lo_q};

      // picture adjustment codes passed straight to the datapath
      assign hue_shift[g*8 +: 8] = hue_q;
      assign saturation_gain[g*8 +: 8] = sat_q;
      assign contrast_gain[g*8 +: 8] = cont_q;
      assign brightness_offset[g*8 +: 8] = brt_q;

      // luma and chroma processing
      assign luma_bandwidth_select[g] = luma_q[LUMA_BW_BIT];
      assign comb_force_trap[g] = trap_q;
      assign peaking_band_select[g] = luma_q[LUMA_PKB_BIT];
      assign peaking_gain[g*4 +: 4] = luma_q[LUMA_PKG_LSB +: 4];
      assign chroma_force_on[g] = alive_q;
      assign chroma_force_kill[g] = kill_q;
      assign transient_boost_gain[g*4 +: 4] =
        chroma_q[CHR_CTI_LSB +: 4];

      // channel control
      assign backdrop_enable[g] = chan_q[CHAN_BGEN_BIT];
      assign backdrop_black[g] = black_q;
      assign soft_reset[g] = chan_q[CHAN_SRST_BIT];
      assign dual_stream_enable[g] = chan_q[CHAN_DUAL_BIT];
      assign partner_channel_select[g*2 +: 2] =
        chan_q[CHAN_PART_LSB +: 2];
    end
  endgenerate

  // top-level read select; indexes past the last channel read zero
  always_comb begin
    rd_data = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      if (ch_hit(reg_idx, c)) rd_data = ch_rd[c];
    end
  end
endmodule
`default_nettype wire

// ==== pkg/vdcc_pkg.sv ====
`default_nettype none
package vdcc_pkg;
  // serial slave address: fixed upper five bits, low two from pins
  localparam logic [4:0] SLV_ADDR_HI = 5'h0A;
  // register index split: channel in [5:4], register in [3:0]
  localparam int CH_LSB = 4;
  localparam int CH_W = 2;
  localparam int REG_W = 4;
  localparam logic [1:0] IDX_TOP_ZERO = 2'h0;
  // register offsets inside one channel
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_FORMAT = 4'h1;
  localparam logic [3:0] OFS_HSTART = 4'h2;
  localparam logic [3:0] OFS_HCOUNT = 4'h3;
  localparam logic [3:0] OFS_VSTART = 4'h4;
  localparam logic [3:0] OFS_VCOUNT = 4'h5;
  localparam logic [3:0] OFS_WINHI = 4'h6;
  localparam logic [3:0] OFS_HUE = 4'h7;
  localparam logic [3:0] OFS_SAT = 4'h8;
  localparam logic [3:0] OFS_CONT = 4'h9;
  localparam logic [3:0] OFS_BRT = 4'hA;
  localparam logic [3:0] OFS_LUMA = 4'hB;
  localparam logic [3:0] OFS_CHROMA = 4'hC;
  localparam logic [3:0] OFS_CHAN = 4'hD;
  // field positions
  localparam int FMT_MAN_BIT = 7;
  localparam int FMT_STD_LSB = 4;
  localparam int FMT_AGC_BIT = 3;
  localparam int FMT_SETUP_BIT = 2;
  localparam int FMT_NONSTD_BIT = 1;
  localparam int FMT_FLD60_BIT = 0;
  localparam int WIN_HS_LSB = 0;
  localparam int WIN_HC_LSB = 2;
  localparam int WIN_VS_BIT = 4;
  localparam int WIN_VC_BIT = 5;
  localparam int LUMA_BW_BIT = 7;
  localparam int LUMA_COMB_LSB = 5;
  localparam int LUMA_PKB_BIT = 4;
  localparam int LUMA_PKG_LSB = 0;
  localparam int CHR_KILL_LSB = 4;
  localparam int CHR_CTI_LSB = 0;
  localparam int CHAN_BGEN_BIT = 6;
  localparam int CHAN_BGCLR_BIT = 5;
  localparam int CHAN_SRST_BIT = 3;
  localparam int CHAN_DUAL_BIT = 2;
  localparam int CHAN_PART_LSB = 0;
  localparam int STAT_STD_LSB = 5;
  localparam int STAT_COLOR_BIT = 4;
  // writable bit masks; other bits stay zero, but format bits 1:0 read back the two flags
  localparam logic [7:0] FMT_WMASK = 8'hFC;
  localparam logic [7:0] WIN_WMASK = 8'h3F;
  localparam logic [7:0] CHR_WMASK = 8'h3F;
  localparam logic [7:0] CHAN_WMASK = 8'h6F;
  // reset values
  localparam logic [7:0] RST_FORMAT = 8'h00;
  localparam logic [7:0] RST_HSTART = 8'h20;
  localparam logic [7:0] RST_HCOUNT = 8'hD0;
  localparam logic [7:0] RST_VSTART = 8'h06;
  localparam logic [7:0] RST_VCOUNT = 8'hF0;
  localparam logic [7:0] RST_WINHI = 8'h08;
  localparam logic [7:0] RST_MID = 8'h80;
  localparam logic [7:0] RST_LUMA = 8'h20;
  localparam logic [7:0] RST_CHROMA = 8'h16;
  localparam logic [7:0] RST_CHAN = 8'h00;
  // field codes
  localparam logic [1:0] COMB_TRAP = 2'h2;
  localparam logic [1:0] KILL_ALIVE = 2'h2;
  localparam logic [1:0] KILL_ALWAYS = 2'h3;
  localparam logic [2:0] STD_PAL_BD = 3'h0;
  localparam logic [2:0] STD_PAL_M = 3'h1;
  localparam logic [2:0] STD_PAL_N = 3'h2;
  localparam logic [2:0] STD_PAL_60 = 3'h3;
  localparam logic [2:0] STD_NTSC_M = 3'h4;
  localparam logic [2:0] STD_NTSC_443 = 3'h5;
  localparam logic [2:0] STD_NTSC_N = 3'h6;
  // soft reset pulse length in core clocks
  localparam logic [2:0] SRST_CYCLES = 3'h4;
endpackage
`default_nettype wire

// ==== verilog/vdcc_serial_slave.sv ====
`default_nettype none
module vdcc_serial_slave
  import vdcc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic [1:0] sadd_i,
  // register side
  output logic [7:0] reg_idx,
  output logic wr_stb,
  output logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  typedef enum {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_IDX, ST_IDX_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } vdcc_ss_state_t;

  logic [2:0] scl_sync_q, sda_sync_q, sadd0_q, sadd1_q;
  logic scl_q, sda_q, scl_prev_q, sda_prev_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  vdcc_ss_state_t state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] out_q;
  logic rnw_q;
  logic drive_q;

  // three-stage sync; level moves only when stages two and three agree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      sadd0_q <= 3'h0;
      sadd1_q <= 3'h0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      sadd0_q <= {sadd0_q[1:0], sadd_i[0]};
      sadd1_q <= {sadd1_q[1:0], sadd_i[1]};
      if (scl_sync_q[1] == scl_sync_q[2]) scl_q <= scl_sync_q[2];
      if (sda_sync_q[1] == sda_sync_q[2]) sda_q <= sda_sync_q[2];
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev_q;
  assign scl_fall = ~scl_q & scl_prev_q;
  assign start_det = scl_q & scl_prev_q & sda_prev_q & ~sda_q;
  assign stop_det = scl_q & scl_prev_q & ~sda_prev_q & sda_q;

  // protocol engine: sample on scl rise, change sda on scl fall
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 8'h00;
      out_q <= 8'h00;
      rnw_q <= 1'b0;
      drive_q <= 1'b0;
      reg_idx <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_det) begin
        state_q <= ST_ADDR;
        bit_cnt_q <= 4'h0;
        drive_q <= 1'b0;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        drive_q <= 1'b0;
      end else if (scl_rise) begin
        shift_q <= {shift_q[6:0], sda_q};
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_fall) begin
        case (state_q)
          ST_ADDR: if (bit_cnt_q == 4'h8) begin
            if (shift_q[7:1] == {SLV_ADDR_HI, sadd1_q[2], sadd0_q[2]}) begin
              rnw_q <= shift_q[0];
              drive_q <= 1'b1;
              state_q <= ST_ADDR_ACK;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          ST_ADDR_ACK: begin
            bit_cnt_q <= 4'h0;
            if (rnw_q) begin
              out_q <= {rd_data[6:0], 1'b0};
              drive_q <= ~rd_data[7];
              state_q <= ST_RDATA;
            end else begin
              drive_q <= 1'b0;
              state_q <= ST_IDX;
            end
          end
          ST_IDX: if (bit_cnt_q == 4'h8) begin
            reg_idx <= shift_q;
            drive_q <= 1'b1;
            state_q <= ST_IDX_ACK;
          end
          ST_WDATA: if (bit_cnt_q == 4'h8) begin
            wr_data <= shift_q;
            wr_stb <= 1'b1;
            drive_q <= 1'b1;
            state_q <= ST_WDATA_ACK;
          end
          ST_IDX_ACK, ST_WDATA_ACK: begin
            // auto-increment once the written byte has been taken
            if (state_q == ST_WDATA_ACK) reg_idx <= reg_idx + 8'h01;
            bit_cnt_q <= 4'h0;
            drive_q <= 1'b0;
            state_q <= ST_WDATA;
          end
          ST_RDATA: begin
            if (bit_cnt_q == 4'h8) begin
              drive_q <= 1'b0;
              reg_idx <= reg_idx + 8'h01;
              state_q <= ST_RACK;
            end else begin
              drive_q <= ~out_q[7];
              out_q <= {out_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bit_cnt_q <= 4'h0;
            if (!shift_q[0]) begin
              out_q <= {rd_data[6:0], 1'b0};
              drive_q <= ~rd_data[7];
              state_q <= ST_RDATA;
            end else begin
              state_q <= ST_IDLE;
            end
          end
          default: drive_q <= 1'b0;
        endcase
      end
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive_q;
endmodule
`default_nettype wire

// ==== dv/vdcc_regs_props.sv ====
`default_nettype none
module vdcc_regs_props #(
  parameter int NCH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n,
  // watched controls
  input wire logic [NCH*8-1:0] hue_shift,
  input wire logic [NCH*10-1:0] h_active_count,
  input wire logic [NCH*4-1:0] transient_boost_gain,
  input wire logic [NCH-1:0] soft_reset,
  input wire logic [NCH-1:0] backdrop_enable,
  input wire logic [NCH-1:0] backdrop_black,
  input wire logic [NCH-1:0] chroma_force_on,
  input wire logic [NCH-1:0] chroma_force_kill
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // run length of the channel 0 soft reset, too long means stuck
  logic [3:0] srst_run_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      srst_run_q <= 4'h0;
    end else if (soft_reset[0]) begin
      srst_run_q <= srst_run_q + 4'h1;
    end else begin
      srst_run_q <= 4'h0;
    end
  end
  // full pulse then a clean drop
  sequence s_pulse;
    soft_reset[0] [*4] ##1 !soft_reset[0];
  endsequence
  // both pins high: no transfer can be landing
  sequence s_idle;
    (scl_i && sda_i) [*8];
  endsequence
  a_srst_pulse: assert property ($rose(soft_reset[0]) |-> s_pulse)
    else $error("soft reset pulse has wrong length");
  a_srst_bound: assert property (srst_run_q <= 4'h4)
    else $error("soft reset held too long");
  a_reset_defaults: assert property ($rose(arst_n) |->
    hue_shift[7:0] == 8'h80 && h_active_count[9:0] == 10'h2D0 &&
    transient_boost_gain[3:0] == 4'h6 && sda_oe_n)
    else $error("controls not at defaults after reset");
  a_black_needs_en: assert property (
    backdrop_black[0] |-> $past(backdrop_enable[0]))
    else $error("black backdrop without backdrop enabled");
  a_kill_exclusive: assert property (
    (chroma_force_on & chroma_force_kill) == '0)
    else $error("chroma forced on and killed together");
  a_idle_stable: assert property (s_idle |=>
    $stable(hue_shift) && $stable(h_active_count))
    else $error("control changed with bus idle");
  a_ack_scl_low: assert property ($changed(sda_oe_n) |-> !scl_i)
    else $error("data line moved while clock high");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data pin value not low");
endmodule

bind vdcc_regs vdcc_regs_props #(.NCH(NCH)) u_props (.*);
`default_nettype wire

// ==== dv/vdcc_host_model.sv ====
`default_nettype none
module vdcc_host_model (
  // core clock paces the bus
  input wire logic core_clk,
  // wired line level and the pins we drive
  input wire logic sda_i,
  output logic scl_i,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idles with both lines released
  initial begin
    scl_i = 1'b1;
    sda_drv = 1'b1;
  end
  // one phase is eight clocks, twice the slave's minimum
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask
  // start, also usable as repeated start
  task automatic start();
    sda_drv = 1'b1;
    half();
    scl_i = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl_i = 1'b0;
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    half();
    scl_i = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask
  // nine bits; a high bit releases so the slave can pull low
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_drv = tx[i];
      half();
      scl_i = 1'b1;
      half();
      rx[i] = sda_i;
      scl_i = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/test_video_decoder_channel_controls.sv ====
`default_nettype none
module test_video_decoder_channel_controls
  import vdcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // pins, status inputs and controls
  logic core_clk, arst_n, scl_i, sda_drv, sda_o, sda_oe_n;
  logic [1:0] sadd_i;
  wire logic sda_i;
  logic [11:0] det_standard, std_active;
  logic [3:0] video_present, color_detected, color_locked, agc_locked;
  logic [3:0] clamp_loop_locked, line_pll_locked, nonstandard_flag;
  logic [3:0] field_rate_flag, agc_enable, setup_level_enable;
  logic [39:0] h_active_start, h_active_count;
  logic [35:0] v_active_start, v_active_count;
  logic [31:0] hue_shift, saturation_gain, contrast_gain, brightness_offset;
  logic [3:0] luma_bandwidth_select, comb_force_trap, peaking_band_select;
  logic [15:0] peaking_gain, transient_boost_gain;
  logic [3:0] chroma_force_on, chroma_force_kill, backdrop_enable;
  logic [3:0] backdrop_black, soft_reset, dual_stream_enable;
  logic [7:0] partner_channel_select, rdat;
  logic [8:0] ack;
  int errors, total_checks, srst_cnt;
  // open drain line with pull-up
  assign sda_i = sda_drv & (sda_oe_n | sda_o);
  vdcc_regs #(.NCH(4)) dut (.*);
  vdcc_host_model host (.core_clk(core_clk), .sda_i(sda_i),
    .scl_i(scl_i), .sda_drv(sda_drv));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // pulse is over before a task returns, so count it here
  always @(negedge core_clk) if (soft_reset[0]) srst_cnt++;
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic addr(logic rw);
    host.xfer({SLV_ADDR_HI, sadd_i, rw, 1'b1}, ack);
    chk("addr ack", ack[0], 1'b0);
  endtask
  task automatic wr(logic [7:0] idx, logic [7:0] d[$]);
    host.start();
    addr(1'b0);
    host.xfer({idx, 1'b1}, ack);
    foreach (d[i]) host.xfer({d[i], 1'b1}, ack);
    host.stop();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic rd(logic [7:0] idx);
    host.start();
    addr(1'b0);
    host.xfer({idx, 1'b1}, ack);
    host.start();
    addr(1'b1);
    host.xfer(9'h1FF, ack);
    rdat = ack[8:1];
    host.stop();
  endtask
  task automatic t_defaults();
    for (int g = 0; g < 4; g++) begin
      chk("hstart", h_active_start[g*10+:10], 10'h020);
      chk("hcount", h_active_count[g*10+:10], 10'h2D0);
      chk("vstart", v_active_start[g*9+:9], 9'h006);
      chk("vcount", v_active_count[g*9+:9], 9'h0F0);
      chk("hue", hue_shift[g*8+:8], 8'h80);
      chk("sat", saturation_gain[g*8+:8], 8'h80);
      chk("cont", contrast_gain[g*8+:8], 8'h80);
      chk("brt", brightness_offset[g*8+:8], 8'h80);
      chk("cti", transient_boost_gain[g*4+:4], 4'h6);
      chk("std", std_active[g*3+:3], STD_PAL_BD);
      chk("agc", agc_enable[g], 1'b0);
    end
    rd(8'h3C);
    chk("chroma reg", rdat, 8'h16);
    rd(8'h1B);
    chk("luma reg", rdat, 8'h20);
  endtask
  task automatic t_std();
    // live video with an odd code, so only the manual bit can pass
    {video_present[0], det_standard[2:0]} = 4'hF;
    for (int c = 0; c < 7; c++) begin
      wr(8'h01, '{{1'b1, c[2:0], 4'hC}});
      chk("manual std", std_active[2:0], c[2:0]);
    end
    chk("agc on", agc_enable[0], 1'b1);
    chk("setup on", setup_level_enable[0], 1'b1);
    nonstandard_flag[0] = 1'b1;
    rd(8'h01);
    chk("format rd", rdat, 8'hEE);
    wr(8'h01, '{8'h53});
    video_present[0] = 1'b1;
    det_standard[2:0] = STD_PAL_N;
    repeat (3) @(negedge core_clk);
    chk("auto std", std_active[2:0], STD_PAL_N);
    video_present[0] = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("free run", std_active[2:0], STD_NTSC_443);
    chk("setup off", setup_level_enable[0], 1'b0);
    nonstandard_flag[0] = 1'b0;
    field_rate_flag[0] = 1'b1;
    rd(8'h01);
    chk("fld rd", rdat, 8'h51);
  endtask
  task automatic t_window();
    wr(8'h12, '{8'hFF, 8'h34, 8'h56, 8'h78, 8'h3F});
    chk("hstart1", h_active_start[19:10], 10'h3FF);
    chk("hcount1", h_active_count[19:10], 10'h334);
    chk("vstart1", v_active_start[17:9], 9'h156);
    chk("vcount1", v_active_count[17:9], 9'h178);
    chk("hstart0", h_active_start[9:0], 10'h020);
    rd(8'h16);
    chk("win hi", rdat, 8'h3F);
  endtask
  task automatic t_pic();
    wr(8'h37, '{8'h00, 8'hFF, 8'h01, 8'h7F});
    chk("hue3", hue_shift[31:24], 8'h00);
    chk("sat3", saturation_gain[31:24], 8'hFF);
    chk("cont3", contrast_gain[31:24], 8'h01);
    chk("brt3", brightness_offset[31:24], 8'h7F);
  endtask
  task automatic t_luma();
    for (int c = 0; c < 4; c++) begin
      wr(8'h2B, '{{c[1], c[1:0], c[0], 2'h2, c[1:0]},
                  {2'h0, c[1:0], 4'hF - c[3:0]}});
      chk("bw", luma_bandwidth_select[2], c[1]);
      chk("trap", comb_force_trap[2], c == 2);
      chk("band", peaking_band_select[2], c[0]);
      chk("pgain", peaking_gain[11:8], 4'h8 + c[3:0]);
      chk("alive", chroma_force_on[2], c == 2);
      chk("kill", chroma_force_kill[2], c == 3);
      chk("cti2", transient_boost_gain[11:8], 4'hF - c[3:0]);
    end
  endtask
  task automatic t_chan();
    wr(8'h0D, '{8'h26});
    chk("black off", backdrop_black[0], 1'b0);
    chk("dual", dual_stream_enable[0], 1'b1);
    chk("partner", partner_channel_select[1:0], 2'h2);
    wr(8'h0D, '{8'h61});
    chk("black on", backdrop_black[0], 1'b1);
    chk("single", dual_stream_enable[0], 1'b0);
    srst_cnt = 0;
    wr(8'h0D, '{8'h69});
    chk("srst len", srst_cnt[15:0], {13'h0, SRST_CYCLES});
    chk("bg kept", backdrop_enable[0], 1'b1);
    rd(8'h0D);
    chk("srst clr", rdat, 8'h61);
  endtask
  task automatic t_status();
    det_standard[5:3] = STD_NTSC_N;
    {color_detected[1], agc_locked[1], line_pll_locked[1]} = 3'h7;
    wr(8'h10, '{8'h00});
    rd(8'h10);
    chk("status", rdat, 8'hD5);
    wr(8'h4F, '{8'hAA});
    rd(8'h4F);
    chk("unmapped", rdat, 8'h00);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    errors++;
    final_report();
  end
  initial begin
    arst_n = 1'b0;
    sadd_i = 2'h2;
    det_standard = '0;
    {video_present, color_detected, color_locked, agc_locked} = '0;
    {clamp_loop_locked, line_pll_locked, nonstandard_flag} = '0;
    field_rate_flag = '0;
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    t_defaults();
    t_std();
    t_window();
    t_pic();
    t_luma();
    t_chan();
    t_status();
    final_report();
  end
endmodule
`default_nettype wire
